/* rtl/spi_status_flag_logic.v */
/*
 * spi status flags with wishbone classic register slave, a sampled
 * serial link (mode 0, msb first) and a masked event interrupt.
 * assumes serial clock much slower than I_CLK (at least 4 cycles per
 * phase) and a peer that drives I_SCK, I_SS_N and I_MOSI.
 */
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ns
`include "spi_flag_defines.vh"
module spi_status_flag_logic (
    input  wire        I_CLK,
    input  wire        I_SYS_RST,
    input  wire        I_WB_CYC,
    input  wire        I_WB_STB,
    input  wire        I_WB_WE,
    input  wire [7:0]  I_WB_ADR,
    input  wire [3:0]  I_WB_SEL,
    input  wire [31:0] I_WB_DAT,
    output reg  [31:0] O_WB_DAT,
    output reg         O_WB_ACK,
    input  wire        I_SCK,
    input  wire        I_SS_N,
    input  wire        I_MOSI,
    output wire        O_MISO,
    output reg         O_IRQ
);
    // ========================================
    // declarations
    wire [2:0] pins_sync;
    wire       sck_s;
    wire       ss_n_s;
    wire       mosi_s;
    reg        sck_prev_q;
    wire       sck_rise;
    wire       sck_fall;

    reg  [2:0] bit_cnt_q;
    reg  [7:0] rx_sh_q;
    reg  [7:0] tx_sh_q;
    wire       done;
    wire [7:0] rx_byte;
    wire       idle;

    reg  [7:0] ctrl_q;
    reg  [7:0] match_reg_q;
    reg  [7:0] rx_buf_q;
    reg  [3:0] ev_mask_q;
    reg  [3:0] ev_q;
    reg  [3:0] ev_set;

    reg        rx_full_q;
    reg        match_q;
    reg        fault_q;
    reg        rx_arm_q;
    reg        match_arm_q;
    reg        fault_arm_q;
    reg        match_chk_q;
    reg        tx_empty_prev_q;

    wire       tx_load;
    wire [7:0] tx_load_data;
    wire       tx_empty;

    wire       acc;
    wire       rd;
    wire       wr;
    wire [5:0] idx;
    wire       status_rd;
    wire       data_rd;
    wire       data_wr;
    wire       status_wr;
    wire       ctrl_wr;
    wire [7:0] status_val;
    wire       rx_set;
    wire       match_set;
    wire       fault_cond;
    wire       fault_set;
    wire       rx_clr;
    wire       fault_clr;
    wire       tx_set;
    reg  [31:0] rd_mux;

    // ========================================
    // link pin synchronisers
    pin_sync #(
        .W (3)
    ) u_sync (
        .i_clk   (I_CLK),
        .i_rst   (I_SYS_RST),
        .i_async ({I_MOSI, I_SS_N, ~I_SCK}),
        .o_sync  (pins_sync)
    );

    // sck held inverted so reset reads idle low
    assign sck_s    = ~pins_sync[0];
    assign ss_n_s   = pins_sync[1];
    assign mosi_s   = pins_sync[2];
    assign sck_rise = sck_s & ~sck_prev_q;
    assign sck_fall = ~sck_s & sck_prev_q;

    // ========================================
    // serial shifter
    assign rx_byte = {rx_sh_q[6:0], mosi_s};
    assign done    = sck_rise & ~ss_n_s & (bit_cnt_q == `BIT_LAST);
    assign idle    = ss_n_s & (bit_cnt_q == `BIT_FIRST);
    assign O_MISO  = tx_sh_q[7];

    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            sck_prev_q <= 1'b0;
            bit_cnt_q  <= `BIT_FIRST;
            rx_sh_q    <= `BYTE_RESET;
            tx_sh_q    <= `BYTE_RESET;
        end else begin
            sck_prev_q <= sck_s;
            if (ss_n_s) begin
                bit_cnt_q <= `BIT_FIRST;
            end else if (sck_rise) begin
                bit_cnt_q <= bit_cnt_q + 3'h1;
                rx_sh_q   <= rx_byte;
            end
            if (tx_load) begin
                tx_sh_q <= tx_load_data;
            end else if (sck_fall & ~ss_n_s & (bit_cnt_q != `BIT_FIRST)) begin
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            end
        end
    end

    // ========================================
    // transmit queue
    spi_tx_queue u_txq (
        .i_clk       (I_CLK),
        .i_rst       (I_SYS_RST),
        .i_status_rd (status_rd),
        .i_data_wr   (data_wr),
        .i_wr_data   (I_WB_DAT[7:0]),
        .i_idle      (idle),
        .i_done      (done),
        .o_load      (tx_load),
        .o_load_data (tx_load_data),
        .o_tx_empty  (tx_empty)
    );

    // ========================================
    // wishbone decode
    assign acc       = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
    assign rd        = acc & ~I_WB_WE;
    assign wr        = acc & I_WB_WE & I_WB_SEL[0];
    assign idx       = I_WB_ADR[7:2];
    assign status_rd = rd & (idx == `IDX_STATUS);
    assign data_rd   = rd & (idx == `IDX_DATA);
    assign data_wr   = wr & (idx == `IDX_DATA);
    assign status_wr = wr & (idx == `IDX_STATUS);
    assign ctrl_wr   = wr & (idx == `IDX_CTRL);

    assign status_val = {rx_full_q, match_q, tx_empty, fault_q,
                         `STAT_LOW_ZERO};

    always @* begin
        rd_mux = 32'h0000_0000;
        case (idx)
            `IDX_CTRL:      rd_mux[7:0] = ctrl_q;
            `IDX_STATUS:    rd_mux[7:0] = status_val;
            `IDX_DATA:      rd_mux[7:0] = rx_buf_q;
            `IDX_MATCH:     rd_mux[7:0] = match_reg_q;
            `IDX_IRQ_MASK:  rd_mux[3:0] = ev_mask_q;
            `IDX_IRQ_EVENT: rd_mux[3:0] = ev_q;
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= 32'h0000_0000;
        end else begin
            O_WB_ACK <= acc;
            if (rd) begin
                O_WB_DAT <= rd_mux;
            end
        end
    end

    // ========================================
    // software registers
    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            ctrl_q      <= `BYTE_RESET;
            match_reg_q <= `BYTE_RESET;
            ev_mask_q   <= `EV_RESET;
        end else begin
            if (ctrl_wr) begin
                ctrl_q <= I_WB_DAT[7:0];
            end
            if (wr & (idx == `IDX_MATCH)) begin
                match_reg_q <= I_WB_DAT[7:0];
            end
            if (wr & (idx == `IDX_IRQ_MASK)) begin
                ev_mask_q <= I_WB_DAT[3:0];
            end
        end
    end

    // ========================================
    // flag set and clear conditions
    assign rx_clr     = data_rd & rx_arm_q;
    assign rx_set     = done & (~rx_full_q | rx_clr);
    assign match_set  = match_chk_q & (rx_buf_q == match_reg_q);
    assign fault_cond = ctrl_q[`CTRL_MASTER] & ctrl_q[`CTRL_FDEN]
                      & ~ctrl_q[`CTRL_SELECT_OUTPUT_ENABLE] & ~ss_n_s;
    assign fault_clr  = ctrl_wr & fault_arm_q;
    assign fault_set  = fault_cond & (~fault_q | fault_clr);
    assign tx_set     = tx_empty & ~tx_empty_prev_q;

    // ========================================
    // receive-full flag and receive buffer
    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            rx_full_q   <= `FLAG_RESET;
            rx_arm_q    <= `FLAG_RESET;
            match_chk_q <= `FLAG_RESET;
            rx_buf_q    <= `BYTE_RESET;
        end else begin
            match_chk_q <= rx_set;
            if (rx_set) begin
                rx_buf_q <= rx_byte;
            end
            if (rx_set) begin
                rx_full_q <= 1'b1;
            end else if (rx_clr) begin
                rx_full_q <= 1'b0;
            end
            if (status_rd) begin
                rx_arm_q <= rx_full_q;
            end else if (data_rd) begin
                rx_arm_q <= 1'b0;
            end
        end
    end

    // ========================================
    // match flag, only write-one clear on status writes
    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            match_q     <= `FLAG_RESET;
            match_arm_q <= `FLAG_RESET;
        end else begin
            if (match_set) begin
                match_q <= 1'b1;
            end else if (status_wr & match_arm_q & I_WB_DAT[`ST_MATCH]) begin
                match_q <= 1'b0;
            end
            if (status_rd) begin
                match_arm_q <= match_q;
            end else if (status_wr) begin
                match_arm_q <= 1'b0;
            end
        end
    end

    // ========================================
    // master fault flag
    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            fault_q     <= `FLAG_RESET;
            fault_arm_q <= `FLAG_RESET;
        end else begin
            if (fault_set) begin
                fault_q <= 1'b1;
            end else if (fault_clr) begin
                fault_q <= 1'b0;
            end
            if (status_rd) begin
                fault_arm_q <= fault_q;
            end else if (ctrl_wr) begin
                fault_arm_q <= 1'b0;
            end
        end
    end

    // ========================================
    // transmit-empty history for the event edge
    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            tx_empty_prev_q <= `TXE_RESET;
        end else begin
            tx_empty_prev_q <= tx_empty;
        end
    end

    // ========================================
    // interrupt events
    always @* begin
        ev_set            = `EV_RESET;
        ev_set[`EV_RXF]   = rx_set;
        ev_set[`EV_MATCH] = match_set;
        ev_set[`EV_TXE]   = tx_set;
        ev_set[`EV_FAULT] = fault_set;
    end

    always @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            ev_q  <= `EV_RESET;
            O_IRQ <= 1'b0;
        end else begin
            if (wr & (idx == `IDX_IRQ_EVENT)) begin
                ev_q <= ev_set | (ev_q & ~I_WB_DAT[3:0]);
            end else begin
                ev_q <= ev_set | ev_q;
            end
            O_IRQ <= |(ev_q & ev_mask_q);
        end
    end
endmodule

/* shared/spi_flag_defines.vh */
/*
 * constants for the spi status-flag block: register indices, bit
 * positions, reset values and counts.
 * assumes a wishbone byte address whose bits [7:2] give the index.
 */
`ifndef SPI_FLAG_DEFINES_VH
`define SPI_FLAG_DEFINES_VH

`define IDX_CTRL      6'h00
`define IDX_STATUS    6'h03
`define IDX_DATA      6'h05
`define IDX_MATCH     6'h07
`define IDX_IRQ_MASK  6'h08
`define IDX_IRQ_EVENT 6'h09

`define ST_RXF        7
`define ST_MATCH      6
`define ST_TXE        5
`define ST_FAULT      4

`define CTRL_MASTER   4
`define CTRL_SELECT_OUTPUT_ENABLE     1
`define CTRL_FDEN     0

`define EV_RXF        0
`define EV_MATCH      1
`define EV_TXE        2
`define EV_FAULT      3

`define TXE_RESET     1'b1
`define FLAG_RESET    1'b0
`define BYTE_RESET    8'h00
`define EV_RESET      4'h0
`define BIT_FIRST     3'h0
`define BIT_LAST      3'h7
`define STAT_LOW_ZERO 4'h0

`endif

/* rtl/pin_sync.v */
/*
 * two-flop synchroniser, one chain per bit.
 * assumes inputs asynchronous to i_clk.
 */
`timescale 1ns/1ns
module pin_sync #(
    parameter W = 3
) (
    input  wire         i_clk,
    input  wire         i_rst,
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    // ========================================
    // per-bit chains
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : chain
            reg meta_q;
            reg sync_q;
            always @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    meta_q <= 1'b1;
                    sync_q <= 1'b1;
                end else begin
                    meta_q <= i_async[g];
                    sync_q <= meta_q;
                end
            end
            assign o_sync[g] = sync_q;
        end
    endgenerate
endmodule

/* rtl/spi_tx_queue.v */
/*
 * transmit buffer, its empty flag and shifter load control.
 * assumes one-cycle strobes for status read and data write.
 */
`timescale 1ns/1ns
`include "spi_flag_defines.vh"
module spi_tx_queue (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire       i_status_rd,
    input  wire       i_data_wr,
    input  wire [7:0] i_wr_data,
    input  wire       i_idle,
    input  wire       i_done,
    output reg        o_load,
    output reg  [7:0] o_load_data,
    output reg        o_tx_empty
);
    reg       arm_q;
    reg       full_q;
    reg [7:0] buf_q;
    reg [7:0] last_q;
    wire      accept;
    wire      load_buf;
    wire      reload;

    // ========================================
    // write acceptance and load decisions
    assign accept   = i_data_wr & arm_q & o_tx_empty;
    assign load_buf = full_q & (i_idle | i_done);
    assign reload   = i_done & ~full_q;

    // ========================================
    // state
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            arm_q       <= `FLAG_RESET;
            full_q      <= `FLAG_RESET;
            buf_q       <= `BYTE_RESET;
            last_q      <= `BYTE_RESET;
            o_load      <= `FLAG_RESET;
            o_load_data <= `BYTE_RESET;
            o_tx_empty  <= `TXE_RESET;
        end else begin
            if (i_status_rd) begin
                arm_q <= o_tx_empty;
            end else if (i_data_wr) begin
                arm_q <= 1'b0;
            end
            if (accept) begin
                full_q <= 1'b1;
                buf_q  <= i_wr_data;
            end else if (load_buf) begin
                full_q <= 1'b0;
            end
            if (load_buf) begin
                o_tx_empty <= 1'b1;
                last_q     <= buf_q;
            end else if (accept) begin
                o_tx_empty <= 1'b0;
            end
            o_load      <= load_buf | reload;
            o_load_data <= load_buf ? buf_q : last_q;
        end
    end
endmodule

/* bench/spi_flag_monitor.sv */
/*
 * port checker for the spi status-flag block.
 * assumes it is bound to spi_status_flag_logic.
 */
`timescale 1ns/1ns
`include "spi_flag_defines.vh"
module spi_flag_monitor (
    input wire        I_CLK,
    input wire        I_SYS_RST,
    input wire        I_WB_CYC,
    input wire        I_WB_STB,
    input wire        I_WB_WE,
    input wire [7:0]  I_WB_ADR,
    input wire [31:0] O_WB_DAT,
    input wire        O_WB_ACK
);
    wire [5:0] idx = I_WB_ADR[7:2];
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    // ====
    // bus sequences
    sequence req_s;
        I_WB_CYC && I_WB_STB && !O_WB_ACK;
    endsequence
    sequence rd_s;
        req_s ##0 !I_WB_WE;
    endsequence
    sequence st_rd_s;
        rd_s ##0 (idx == `IDX_STATUS);
    endsequence
    // ====
    // assertions
    ack_latency_a: assert property (req_s |=> O_WB_ACK)
        else $error("no ack one cycle after request");
    ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB))
        else $error("ack without request");
    rdata_hold_a: assert property (!(O_WB_ACK && !$past(I_WB_WE)) |-> $stable(O_WB_DAT))
        else $error("read data moved without a read");
    stat_low_a: assert property (st_rd_s |=> O_WB_DAT[3:0] == `STAT_LOW_ZERO)
        else $error("status low bits not zero");
    narrow_rd_a: assert property (rd_s ##0 (idx == `IDX_CTRL || idx == `IDX_STATUS
        || idx == `IDX_DATA || idx == `IDX_MATCH) |=> O_WB_DAT[31:8] == 24'h0)
        else $error("byte register upper bits set");
    irq_rd_a: assert property (rd_s ##0 (idx == `IDX_IRQ_MASK || idx == `IDX_IRQ_EVENT)
        |=> O_WB_DAT[31:4] == 28'h0)
        else $error("irq register upper bits set");
    unmapped_a: assert property (rd_s ##0 (idx > `IDX_IRQ_EVENT) |=> O_WB_DAT == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind spi_status_flag_logic spi_flag_monitor mon (
    .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
    .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK));

/* bench/spi_peer.sv */
/*
 * spi master model, mode 0, msb first, 400 ns clock.
 * assumes the block samples sck with its own clock.
 */
`timescale 1ns/1ns
module spi_peer (
    output reg  o_sck,
    output reg  o_ss_n,
    output reg  o_mosi,
    input  wire i_miso
);
    initial begin
        o_sck = 1'b0;
        o_ss_n = 1'b1;
        o_mosi = 1'b1;
    end
    // ====
    // one byte frame, clock still outside it
    task xfer(input [7:0] tx, input hold, output [7:0] rx);
        integer i;
        begin
            #10;
            o_ss_n = 1'b0;
            for (i = 7; i >= 0; i = i - 1) begin
                o_mosi = tx[i];
                #200;
                o_sck = 1'b1;
                rx[i] = i_miso;
                #200;
                o_sck = 1'b0;
            end
            #200;
            o_mosi = ~o_mosi;
            if (!hold) o_ss_n = 1'b1;
        end
    endtask
endmodule

/* bench/tb.sv */
/*
 * bench top: wishbone master, spi peer and read checks.
 * assumes spi_status_flag_logic and spi_peer.
 */
`timescale 1ns/1ns
`include "spi_flag_defines.vh"
module tb;
    reg         clk, rst, cyc, stb, we;
    reg  [7:0]  adr, d1, d2, p1, r1, r2, r3;
    reg  [3:0]  sel;
    reg  [31:0] wdat, m;
    wire [31:0] rdat;
    wire        ack, sck, ss_n, mosi, miso, irq;
    integer     n_errors, check_count, seed, cycles;
    reg  [31:0] exp_q[$];
    reg  [31:0] msk_q[$];
    localparam [7:0] a_st = {`IDX_STATUS, 2'b00};
    localparam [7:0] a_dat = {`IDX_DATA, 2'b00};
    localparam [7:0] a_cmp = {`IDX_MATCH, 2'b00};
    localparam [7:0] a_ctl = {`IDX_CTRL, 2'b00};
    localparam [7:0] a_msk = {`IDX_IRQ_MASK, 2'b00};
    localparam [7:0] a_ev = {`IDX_IRQ_EVENT, 2'b00};

    spi_status_flag_logic dut (.I_CLK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
        .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_SCK(sck), .I_SS_N(ss_n), .I_MOSI(mosi),
        .O_MISO(miso), .O_IRQ(irq));
    spi_peer peer (.o_sck(sck), .o_ss_n(ss_n), .o_mosi(mosi), .i_miso(miso));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ====
    // checks and closing
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("unexpected %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task finish_test;
        begin
            $display("errors %0d checks %0d", n_errors, check_count);
            if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // ====
    // wishbone classic master
    task wb(input w, input [7:0] a, input [31:0] d);
        begin
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= d;
            sel <= 4'h1;
            @(posedge clk);
            while (ack !== 1'b1) begin
                @(posedge clk);
            end
            cyc <= 1'b0;
            stb <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd(input [7:0] a, input [31:0] e, input [31:0] k);
        begin
            exp_q.push_back(e);
            msk_q.push_back(k);
            wb(1'b0, a, 32'h0);
        end
    endtask
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            m = msk_q.pop_front();
            chk("read data", exp_q.pop_front() & m, rdat & m);
        end
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            finish_test;
        end
    end
    // ====
    // main sequence
    initial begin
        n_errors = 0;
        check_count = 0;
        cycles = 0;
        seed = 80492;
        rst = 1'b1;
        {cyc, stb, we, adr, sel, wdat} = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        d1 = $random(seed);
        d2 = $random(seed);
        p1 = $random(seed);
        rd(a_st, 32'h20, 32'hffffffff);
        rd(8'hfc, 32'h0, 32'hffffffff);
        rd(a_msk, 32'h0, 32'hffffffff);
        wb(1'b1, a_cmp, {24'h0, p1});
        wb(1'b1, a_dat, {24'h0, d1});
        wb(1'b1, a_dat, {24'h0, ~d1});
        rd(a_st, 32'h20, 32'hff);
        fork
            peer.xfer(p1, 1'b0, r1);
            begin
                repeat (10) @(posedge clk);
                rd(a_st, 32'h20, 32'hff);
                wb(1'b1, a_dat, {24'h0, d2});
                rd(a_st, 32'h00, 32'hff);
            end
        join
        chk("first byte", {24'h0, d1}, {24'h0, r1});
        repeat (8) @(posedge clk);
        rd(a_dat, {24'h0, p1}, 32'hff);
        rd(a_st, 32'he0, 32'hff);
        wb(1'b1, a_st, 32'h00);
        rd(a_st, 32'he0, 32'hff);
        wb(1'b1, a_st, 32'h40);
        rd(a_st, 32'ha0, 32'hff);
        rd(a_dat, {24'h0, p1}, 32'hff);
        rd(a_st, 32'h20, 32'hff);
        peer.xfer(p1 ^ 8'h01, 1'b1, r2);
        peer.xfer(8'h00, 1'b0, r3);
        chk("queued byte", {24'h0, d2}, {24'h0, r2});
        chk("resent byte", {24'h0, d2}, {24'h0, r3});
        repeat (8) @(posedge clk);
        rd(a_st, 32'ha0, 32'hff);
        chk("irq masked", 32'h0, {31'h0, irq});
        wb(1'b1, a_msk, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        wb(1'b1, a_ev, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wb(1'b1, a_ctl, 32'h11);
        peer.xfer(8'h00, 1'b0, r3);
        wb(1'b1, a_ctl, 32'h11);
        rd(a_st, 32'h10, 32'h10);
        wb(1'b1, a_ctl, 32'h11);
        rd(a_st, 32'h00, 32'h10);
        wb(1'b1, a_ctl, 32'h13);
        peer.xfer(8'h00, 1'b0, r3);
        rd(a_st, 32'h00, 32'h10);
        finish_test;
    end
endmodule
